// *** slpm_top.sv ***
`timescale 1ns/1ps
module slpm_top
	import slpm_pkg::*;
#(
	parameter int unsigned DELAY_CYCLES = STRAP_DELAY_CYCLES
) (
	input wire logic clock, // System clock, 100 MHz
	input wire logic arst_n, // Async reset, active low
	input wire logic por_released, // POR complete or external POR released
	input wire logic [N_GPIO-1:0] gpio_in, // GPIO pad levels
	output logic [N_GPIO-1:0] gpio_out, // GPIO pad drive value
	output logic [N_GPIO-1:0] gpio_oe, // GPIO pad drive enable
	output logic [N_GPIO-1:0] gpio_pd_en, // GPIO weak pull-down enable
	input wire logic [N_RF-1:0] rf_in, // RF switch pad levels
	output logic [N_RF-1:0] rf_out, // RF switch pad drive value
	output logic [N_RF-1:0] rf_oe, // RF switch pad drive enable
	output logic [N_RF-1:0] rf_pd_en, // RF switch weak pull-down enable
	input wire logic sel_wr_en, // Selector write strobe
	input wire logic [PAD_W-1:0] sel_wr_pad, // Pad index to write
	input wire logic [SEL_W-1:0] sel_wr_func, // Function number to store
	input wire logic [N_RF-1:0] rf_sw_level, // Software RF line levels
	input wire logic [N_GPIO-1:0] gpio_core_out, // GPIO controller output
	input wire logic [N_GPIO-1:0] gpio_core_oe, // GPIO controller enable
	output logic [N_GPIO-1:0] gpio_core_in, // Synchronised GPIO levels
	input wire logic [N_PWM-1:0] pulse_out, // PWM controller outputs
	input wire logic [N_COEX-1:0] coex_general_io_out, // Coex GPIO outputs
	input wire logic [N_COEX-1:0] coex_general_io_oe, // Coex GPIO enables
	output logic [N_COEX-1:0] coex_general_io_in, // Coex GPIO inputs
	input wire logic debug_serial_tx, // Second UART transmit
	output logic debug_serial_rx, // Second UART receive
	input wire logic coex_serial_out, // Third UART transmit
	output logic coex_serial_in, // Third UART receive
	input wire logic jtag_select, // JTAG select pin
	input wire logic jtag_tdo, // Test data out from TAP
	output logic jtag_tck, // Test clock to TAP
	output logic jtag_tms, // Test mode select to TAP
	output logic jtag_tdi, // Test data in to TAP
	output logic jtag_trst_n, // Test reset to TAP, active low
	input wire logic [1:0] audio_serial_data, // Audio serial data per port
	input wire logic spdif_data, // S/PDIF encoded stream
	input wire logic [1:0] spdif_enable, // Put S/PDIF on audio pin 0 or 1
	output logic audio_data_out_0, // Audio data pad 0
	output logic audio_data_out_1, // Audio data pad 1
	input wire logic [1:0] two_wire_mode, // Serial port runs two-wire
	input wire logic [1:0] spi_clk, // Serial port clock
	input wire logic [1:0] spi_mosi, // Serial port data out
	output logic [1:0] spi_miso, // Serial port data in
	input wire logic [1:0] scl_drive_low, // Two-wire clock pull low
	input wire logic [1:0] sda_drive_low, // Two-wire data pull low
	output logic [1:0] two_wire_sda_in, // Two-wire data level
	input wire logic [1:0] spi_miso_pad, // Data-in pad level
	input wire logic [1:0] spi_mosi_pad_in, // Data-out pad level
	output logic [1:0] spi_clk_pad, // Clock pad drive value
	output logic [1:0] spi_clk_pad_oe, // Clock pad drive enable
	output logic [1:0] spi_mosi_pad, // Data-out pad drive value
	output logic [1:0] spi_mosi_pad_oe, // Data-out pad drive enable
	input wire logic usb_role_select, // USB role pin
	output logic usb_host_mode, // USB role after synchroniser
	output logic generic_serial_host_enable_strap, // Strap from GPIO 1
	output logic wireless_cpu_boot_source_strap, // Strap from GPIO 7
	output logic app_cpu_boot_source_strap, // Strap from GPIO 11
	output logic sdio_host_mode_strap, // Strap from GPIO 13
	output logic power_trim_enable_strap, // Strap from GPIO 15
	output logic debug_port_clock_select_strap, // Strap from RF line 5
	output logic resource_init_mode_strap, // Strap from RF line 7
	output logic strap_done // Straps latched, pads released
);
	// ************************************************************
	// PWM routing table for GPIO pads
	// ************************************************************
	function automatic logic [2:0] pwm_route(input logic [PAD_W-1:0] pin,
			input logic [SEL_W-1:0] f);
		logic [8:0] key;
		key = {pin, f};
		case (key)
			9'h004: pwm_route = 3'h0;
			9'h006: pwm_route = 3'h2;
			9'h00a: pwm_route = 3'h4;
			9'h014: pwm_route = 3'h1;
			9'h016: pwm_route = 3'h3;
			9'h01a: pwm_route = 3'h5;
			9'h073: pwm_route = 3'h1;
			9'h074: pwm_route = 3'h3;
			9'h07b: pwm_route = 3'h5;
			9'h083: pwm_route = 3'h2;
			9'h084: pwm_route = 3'h4;
			9'h08b: pwm_route = 3'h0;
			9'h093: pwm_route = 3'h3;
			9'h094: pwm_route = 3'h5;
			9'h09b: pwm_route = 3'h1;
			9'h0a3: pwm_route = 3'h4;
			9'h0a6: pwm_route = 3'h0;
			9'h0a9: pwm_route = 3'h2;
			9'h0b3: pwm_route = 3'h5;
			9'h0b6: pwm_route = 3'h1;
			9'h0b9: pwm_route = 3'h3;
			9'h0c5: pwm_route = 3'h2;
			9'h0c6: pwm_route = 3'h4;
			9'h0c9: pwm_route = 3'h0;
			9'h0d5: pwm_route = 3'h3;
			9'h0d6: pwm_route = 3'h5;
			9'h0d9: pwm_route = 3'h1;
			9'h0e2: pwm_route = 3'h0;
			9'h0e9: pwm_route = 3'h4;
			9'h0eb: pwm_route = 3'h2;
			9'h0f2: pwm_route = 3'h1;
			9'h0f9: pwm_route = 3'h5;
			9'h0fb: pwm_route = 3'h3;
			9'h103: pwm_route = 3'h0;
			9'h104: pwm_route = 3'h2;
			9'h10b: pwm_route = 3'h4;
			default: pwm_route = PWM_NONE;
		endcase
	endfunction

	// ************************************************************
	// Synchronisers and strap delay
	// ************************************************************
	logic [N_GPIO-1:0] gpio_s;
	logic [N_RF-1:0] rf_s;
	logic por_s;
	logic jtag_s;
	logic [1:0] miso_s;
	logic [1:0] sda_s;
	logic delay_done;
	slpm_state_t state_r;
	slpm_state_t state_nxt;
	logic [SEL_W-1:0] sel_r [N_PAD];
	logic [6:0] straps_r;
	logic [6:0] straps_nxt;
	wire run = (state_r == SLPM_RUN);
	wire jtag_on = jtag_s;

	// Every pad-side input crosses into the clock domain first, the USB role pin too
	slpm_sync #(.W(N_GPIO + N_RF + 7)) u_sync (
		.clock(clock),
		.arst_n(arst_n),
		.d({gpio_in, rf_in, por_released, jtag_select, usb_role_select,
			spi_miso_pad, spi_mosi_pad_in}),
		.q({gpio_s, rf_s, por_s, jtag_s, usb_host_mode, miso_s, sda_s})
	);

	slpm_delay #(.CYCLES(DELAY_CYCLES)) u_delay (
		.clock(clock),
		.arst_n(arst_n),
		.start(state_r == SLPM_DELAY),
		.done(delay_done)
	);

	// ************************************************************
	// Strap sequence
	// ************************************************************
	// One pass per reset; a later POR glitch cannot re-latch modes
	always_comb begin
		case (state_r)
			SLPM_WAIT_POR: state_nxt = por_s ? SLPM_DELAY : SLPM_WAIT_POR;
			SLPM_DELAY: state_nxt = delay_done ? SLPM_CAPTURE : SLPM_DELAY;
			SLPM_CAPTURE: state_nxt = SLPM_RUN;
			SLPM_RUN: state_nxt = SLPM_RUN;
			default: state_nxt = SLPM_WAIT_POR;
		endcase
	end

	// Strap sampling order: gspi, wcpu, acpu, sdio, vtrim, dap, rsrc
	assign straps_nxt = (state_r == SLPM_CAPTURE) ? {gpio_s[GPIO_GSPI], gpio_s[GPIO_WCPU],
		gpio_s[GPIO_ACPU], gpio_s[GPIO_SDIO], gpio_s[GPIO_VTRIM], rf_s[RF_DAPCLK],
		rf_s[RF_RSRC]} : straps_r;
	assign generic_serial_host_enable_strap = straps_r[6];
	assign wireless_cpu_boot_source_strap = straps_r[5];
	assign app_cpu_boot_source_strap = straps_r[4];
	assign sdio_host_mode_strap = straps_r[3];
	assign power_trim_enable_strap = straps_r[2];
	assign debug_port_clock_select_strap = straps_r[1];
	assign resource_init_mode_strap = straps_r[0];
	assign strap_done = run;
	// Pulls on straps only until capture ends; unconnected reads zero
	assign gpio_pd_en = run ? '0 : STRAP_GPIO_MASK;
	assign rf_pd_en = run ? '0 : STRAP_RF_MASK;

	// ************************************************************
	// GPIO pad selection
	// ************************************************************
	logic [N_GPIO-1:0] gpio_out_nxt;
	logic [N_GPIO-1:0] gpio_oe_nxt;
	genvar gi;
	generate
		for (gi = 0; gi < N_GPIO; gi++) begin : g_gpio
			localparam bit IS_JT = (gi >= JTAG_TCK_PIN) && (gi <= JTAG_TRST_PIN);
			localparam int CX = IS_JT ? gi - COEX_GPIO_BASE : 0;
			localparam bit IS_TDO = (gi == JTAG_TDO_PIN);
			wire [SEL_W-1:0] sel = sel_r[gi];
			wire [2:0] pidx = pwm_route(PAD_W'(gi), sel);
			wire phit = (pidx != PWM_NONE);
			wire nat = (sel == FUNC_NATIVE);
			wire jt = IS_JT && jtag_on;
			wire cx = IS_JT && (sel == FUNC_COEX);
			// JTAG wins over any stored selection on its five pins
			assign gpio_out_nxt[gi] = jt ? (IS_TDO && jtag_tdo) : nat ? gpio_core_out[gi] :
				cx ? coex_general_io_out[CX] : phit && pulse_out[pidx];
			assign gpio_oe_nxt[gi] = run && (jt ? IS_TDO : nat ? gpio_core_oe[gi] :
				cx ? coex_general_io_oe[CX] : phit);
		end
	endgenerate

	// ************************************************************
	// RF switch line selection
	// ************************************************************
	logic [N_RF-1:0] rf_out_nxt;
	logic [N_RF-1:0] rf_oe_nxt;
	genvar rj;
	generate
		for (rj = 0; rj < N_RF; rj++) begin : g_rf
			wire [SEL_W-1:0] sel = sel_r[RF_BASE + rj];
			wire a2 = (sel == FUNC_ALT2);
			wire a3 = (sel == FUNC_ALT3);
			wire nat = (sel == FUNC_NATIVE);
			wire tx_dbg = ((rj == RF_TX_A) && a2) || ((rj == RF_TX_B) && a3);
			wire tx_cx = ((rj == RF_TX_A) && a3) || ((rj == RF_TX_B) && a2);
			wire io5 = (rj == RF_COEX_IO) && a2;
			assign rf_out_nxt[rj] = nat ? rf_sw_level[rj] : tx_dbg ? debug_serial_tx :
				tx_cx ? coex_serial_out : io5 && coex_general_io_out[RF_COEX_IO];
			assign rf_oe_nxt[rj] = run && (nat || tx_dbg || tx_cx ||
				(io5 && coex_general_io_oe[RF_COEX_IO]));
		end
	endgenerate

	// Receive sides idle high when no line is routed to them
	assign debug_serial_rx = (sel_r[RF_BASE + RF_RX_A] == FUNC_ALT2) ? rf_s[RF_RX_A] :
		(sel_r[RF_BASE + RF_RX_B] == FUNC_ALT3) ? rf_s[RF_RX_B] : 1'b1;
	assign coex_serial_in = (sel_r[RF_BASE + RF_RX_A] == FUNC_ALT3) ? rf_s[RF_RX_A] :
		(sel_r[RF_BASE + RF_RX_B] == FUNC_ALT2) ? rf_s[RF_RX_B] : 1'b1;

	// ************************************************************
	// Core-side inputs
	// ************************************************************
	assign gpio_core_in = gpio_s;
	assign coex_general_io_in = {rf_s[RF_COEX_IO], gpio_s[JTAG_TRST_PIN:COEX_GPIO_BASE]};
	// TAP sees a held reset while JTAG is off the pads
	assign jtag_tck = jtag_on && gpio_s[JTAG_TCK_PIN];
	assign jtag_tms = !jtag_on || gpio_s[JTAG_TMS_PIN];
	assign jtag_tdi = jtag_on && gpio_s[JTAG_TDI_PIN];
	assign jtag_trst_n = jtag_on && gpio_s[JTAG_TRST_PIN];
	assign spi_miso = miso_s;
	assign two_wire_sda_in = sda_s;

	// ************************************************************
	// Serial ports, audio pads and selector store
	// ************************************************************
	// Two-wire role is open-drain: pads only ever pull low
	wire [1:0] clk_nxt = two_wire_mode ^ (two_wire_mode | spi_clk);
	wire [1:0] clk_oe_nxt = two_wire_mode & scl_drive_low | ~two_wire_mode;
	wire [1:0] mosi_nxt = ~two_wire_mode & spi_mosi;
	wire [1:0] mosi_oe_nxt = two_wire_mode & sda_drive_low | ~two_wire_mode;
	wire aud0_nxt = spdif_enable[0] ? spdif_data : audio_serial_data[0];
	wire aud1_nxt = spdif_enable[1] ? spdif_data : audio_serial_data[1];
	wire sel_hit = sel_wr_en && (sel_wr_pad < PAD_W'(N_PAD));

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int k = 0; k < N_PAD; k++) begin
				sel_r[k] <= FUNC_NATIVE;
			end
		end else if (sel_hit) begin
			sel_r[sel_wr_pad] <= sel_wr_func;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= SLPM_WAIT_POR;
			straps_r <= '0;
			{gpio_out, gpio_oe, rf_out, rf_oe} <= '0;
			{audio_data_out_0, audio_data_out_1} <= '0;
			{spi_clk_pad, spi_clk_pad_oe, spi_mosi_pad, spi_mosi_pad_oe} <= '0;
		end else begin
			state_r <= state_nxt;
			straps_r <= straps_nxt;
			{gpio_out, gpio_oe, rf_out, rf_oe} <= {gpio_out_nxt, gpio_oe_nxt, rf_out_nxt, rf_oe_nxt};
			{audio_data_out_0, audio_data_out_1} <= {aud0_nxt, aud1_nxt};
			{spi_clk_pad, spi_clk_pad_oe, spi_mosi_pad, spi_mosi_pad_oe} <=
				{clk_nxt, clk_oe_nxt, mosi_nxt, mosi_oe_nxt};
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	a_straps_held:
	assert property (@(posedge clock) disable iff (!arst_n)
		strap_done && $past(strap_done) |-> $stable(straps_r))
		else $error("straps changed after capture");
	a_capture_late:
	assert property (@(posedge clock) disable iff (!arst_n)
		$rose(strap_done) |-> $past(delay_done, 2))
		else $error("straps latched before delay ended");
	a_pads_quiet:
	assert property (@(posedge clock) disable iff (!arst_n)
		!strap_done |-> (gpio_oe == '0) && (rf_oe == '0))
		else $error("pad driven before capture");
	a_strap_pulls:
	assert property (@(posedge clock) disable iff (!arst_n)
		!strap_done |-> gpio_pd_en == STRAP_GPIO_MASK && rf_pd_en == STRAP_RF_MASK)
		else $error("strap pull missing during capture");
	a_boot_capture:
	assert property (@(posedge clock) disable iff (!arst_n)
		$rose(strap_done) |-> wireless_cpu_boot_source_strap == $past(gpio_s[GPIO_WCPU])
		&& app_cpu_boot_source_strap == $past(gpio_s[GPIO_ACPU]))
		else $error("boot strap not taken from its pin");
	a_jtag_pins:
	assert property (@(posedge clock) disable iff (!arst_n)
		$past(jtag_on && run) |-> gpio_oe[JTAG_TDO_PIN] && !gpio_oe[JTAG_TCK_PIN]
		&& gpio_out[JTAG_TDO_PIN] == $past(jtag_tdo))
		else $error("jtag pins not overriding");
	a_rf_level:
	assert property (@(posedge clock) disable iff (!arst_n)
		$past(run && sel_r[RF_BASE] == FUNC_NATIVE) |-> rf_oe[0] && rf_out[0] == $past(rf_sw_level[0]))
		else $error("rf line 0 not following level");
	a_spdif_route:
	assert property (@(posedge clock) disable iff (!arst_n)
		$past(spdif_enable[1]) |-> audio_data_out_1 == $past(spdif_data))
		else $error("spdif not on audio pin 1");
	a_usb_role:
	assert property (@(posedge clock) disable iff (!arst_n)
		$past(arst_n, 2) |-> usb_host_mode == $past(usb_role_select, 2))
		else $error("usb role not following pin");
endmodule

// *** slpm_pkg.sv ***
package slpm_pkg;

	// ************************************************************
	// Clock and strap timing
	// ************************************************************
	localparam int CLK_MHZ = 100;
	localparam int STRAP_DELAY_US = 2000;
	// Delay is a least time; whole microseconds at an integer MHz rate
	localparam int STRAP_DELAY_CYCLES = STRAP_DELAY_US * CLK_MHZ;
	localparam int CNT_W = 24;

	// ************************************************************
	// Pad counts and selector layout
	// ************************************************************
	localparam int N_GPIO = 17;
	localparam int N_RF = 10;
	localparam int N_PWM = 6;
	localparam int N_COEX = 6;
	localparam int N_PAD = 27;
	localparam int RF_BASE = 17;
	localparam int SEL_W = 4;
	localparam int PAD_W = 5;
	localparam logic [SEL_W-1:0] FUNC_NATIVE = 4'h1;
	localparam logic [SEL_W-1:0] FUNC_ALT2 = 4'h2;
	localparam logic [SEL_W-1:0] FUNC_ALT3 = 4'h3;
	localparam logic [SEL_W-1:0] FUNC_COEX = 4'h4;
	localparam logic [2:0] PWM_NONE = 3'h7;

	// ************************************************************
	// Strap pins and captured strap positions
	// ************************************************************
	localparam logic [N_GPIO-1:0] STRAP_GPIO_MASK = 17'h0a882;
	localparam logic [N_RF-1:0] STRAP_RF_MASK = 10'h0a0;
	localparam int GPIO_GSPI = 1;
	localparam int GPIO_WCPU = 7;
	localparam int GPIO_ACPU = 11;
	localparam int GPIO_SDIO = 13;
	localparam int GPIO_VTRIM = 15;
	localparam int RF_DAPCLK = 5;
	localparam int RF_RSRC = 7;

	// ************************************************************
	// Fixed pin roles
	// ************************************************************
	localparam int JTAG_TCK_PIN = 2;
	localparam int JTAG_TMS_PIN = 3;
	localparam int JTAG_TDI_PIN = 4;
	localparam int JTAG_TDO_PIN = 5;
	localparam int JTAG_TRST_PIN = 6;
	localparam int COEX_GPIO_BASE = 2;
	localparam int RF_COEX_IO = 5;
	localparam int RF_RX_A = 6;
	localparam int RF_TX_A = 7;
	localparam int RF_RX_B = 8;
	localparam int RF_TX_B = 9;

	typedef enum logic [3:0] {
		SLPM_WAIT_POR = 4'h1,
		SLPM_DELAY = 4'h2,
		SLPM_CAPTURE = 4'h4,
		SLPM_RUN = 4'h8
	} slpm_state_t;

endpackage

// *** slpm_sync.sv ***
`timescale 1ns/1ps
module slpm_sync #(
	parameter int W = 1
) (
	input wire logic clock, // System clock
	input wire logic arst_n, // Async reset, active low
	input wire logic [W-1:0] d, // Asynchronous inputs
	output logic [W-1:0] q // Synchronised outputs
);
	logic [W-1:0] meta_r;

	// Two stages; only the second stage is visible
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// *** slpm_delay.sv ***
`timescale 1ns/1ps
module slpm_delay
	import slpm_pkg::*;
#(
	parameter int unsigned CYCLES = STRAP_DELAY_CYCLES
) (
	input wire logic clock, // System clock
	input wire logic arst_n, // Async reset, active low
	input wire logic start, // Hold high to count
	output logic done // High once CYCLES counted
);
	localparam logic [CNT_W-1:0] LIMIT = CNT_W'(CYCLES - 1);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;

	// Counter restarts whenever start drops
	assign cnt_nxt = !start ? '0 : (cnt_r == LIMIT) ? cnt_r : cnt_r + 1'b1;
	assign done = start && (cnt_r == LIMIT);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// *** slpm_board_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// Board strap resistors and external pad drivers
// ************************************************************
module slpm_board_model
	import slpm_pkg::*;
(
	input wire logic [N_GPIO-1:0] gpio_out, // Device drive value
	input wire logic [N_GPIO-1:0] gpio_oe, // Device drive enable
	input wire logic [N_GPIO-1:0] gpio_pd_en, // Device weak pull-down
	input wire logic [N_GPIO-1:0] pu_gpio, // Board pull-up fitted
	input wire logic [N_GPIO-1:0] ext_gpio, // Peripheral level on pad
	output logic [N_GPIO-1:0] gpio_in, // Resolved pad level
	input wire logic [N_RF-1:0] rf_out, // Device drive value
	input wire logic [N_RF-1:0] rf_oe, // Device drive enable
	input wire logic [N_RF-1:0] rf_pd_en, // Device weak pull-down
	input wire logic [N_RF-1:0] pu_rf, // Board pull-up fitted
	input wire logic [N_RF-1:0] ext_rf, // Peripheral level on pad
	output logic [N_RF-1:0] rf_in // Resolved pad level
);
	// Device drive wins; a 10k board pull beats the weak pull-down
	assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & (pu_gpio | (~gpio_pd_en & ext_gpio)));
	// Same resolution on the RF switch lines
	assign rf_in = (rf_oe & rf_out) | (~rf_oe & (pu_rf | (~rf_pd_en & ext_rf)));
endmodule

// *** test_strap_latch_and_pin_mux.sv ***
`timescale 1ns/1ps
module test_strap_latch_and_pin_mux
	import slpm_pkg::*;
;
	localparam int D = 16;
	logic clock, arst_n, por_released, sel_wr_en, debug_serial_tx, coex_serial_out, jtag_select;
	logic jtag_tdo, spdif_data, usb_role_select, debug_serial_rx, coex_serial_in, jtag_tck;
	logic jtag_tms, jtag_tdi, jtag_trst_n, audio_data_out_0, audio_data_out_1, usb_host_mode;
	logic strap_done, generic_serial_host_enable_strap, wireless_cpu_boot_source_strap;
	logic app_cpu_boot_source_strap, sdio_host_mode_strap, power_trim_enable_strap;
	logic debug_port_clock_select_strap, resource_init_mode_strap;
	logic [N_GPIO-1:0] gpio_in, gpio_out, gpio_oe, gpio_pd_en, gpio_core_out, gpio_core_oe;
	logic [N_GPIO-1:0] gpio_core_in, pu_gpio, ext_gpio;
	logic [N_RF-1:0] rf_in, rf_out, rf_oe, rf_pd_en, rf_sw_level, pu_rf, ext_rf;
	logic [PAD_W-1:0] sel_wr_pad;
	logic [SEL_W-1:0] sel_wr_func;
	logic [N_PWM-1:0] pulse_out;
	logic [N_COEX-1:0] coex_general_io_out, coex_general_io_oe, coex_general_io_in;
	logic [1:0] audio_serial_data, spdif_enable, two_wire_mode, spi_clk, spi_mosi, spi_miso;
	logic [1:0] scl_drive_low, sda_drive_low, two_wire_sda_in, spi_miso_pad, spi_mosi_pad_in;
	logic [1:0] spi_clk_pad, spi_clk_pad_oe, spi_mosi_pad, spi_mosi_pad_oe;
	int num_errors, tests_run, n;
	wire [6:0] straps = {generic_serial_host_enable_strap, wireless_cpu_boot_source_strap,
		app_cpu_boot_source_strap, sdio_host_mode_strap, power_trim_enable_strap,
		debug_port_clock_select_strap, resource_init_mode_strap};

	// ************************************************************
	// Device, board model and clock
	// ************************************************************
	slpm_top #(.DELAY_CYCLES(D)) i_dut (.*);
	slpm_board_model i_board (.*);
	always #5 clock = ~clock;

	// ************************************************************
	// Shared tasks
	// ************************************************************
	// Inputs only move at falling edges, so no race with the rising edge
	task tick(input int k);
		repeat (k) @(negedge clock);
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
		tests_run++;
	endtask

	task results;
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Selector write, then two edges for selector and pad registers
	task wr(input int p, input logic [3:0] f);
		sel_wr_en = 1'b1;
		sel_wr_pad = PAD_W'(p);
		sel_wr_func = f;
		tick(1);
		sel_wr_en = 1'b0;
		tick(2);
	endtask

	task do_reset;
		arst_n = 1'b0;
		tick(10);
		chk("gpio_pd_en", STRAP_GPIO_MASK, gpio_pd_en); // Pulls on
		chk("rf_pd_en", STRAP_RF_MASK, rf_pd_en); // Pulls on
		chk("gpio_oe", 0, gpio_oe); // Pads released
		chk("straps", 0, {straps, strap_done}); // Nothing latched
		arst_n = 1'b1;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{clock, arst_n, por_released, sel_wr_en, coex_serial_out, jtag_select, jtag_tdo} = '0;
		{usb_role_select, sel_wr_pad, sel_wr_func, spi_mosi, sda_drive_low, spi_miso_pad} = '0;
		{two_wire_mode, scl_drive_low, spdif_enable, coex_general_io_out} = '0;
		debug_serial_tx = 1'b1;
		spdif_data = 1'b1;
		audio_serial_data = 2'b10;
		spi_clk = 2'b11;
		spi_mosi_pad_in = 2'b10;
		pu_gpio = 17'h08802;
		pu_rf = 10'h080;
		ext_gpio = 17'h1ffef;
		ext_rf = 10'h000;
		gpio_core_out = 17'h1a5a5;
		gpio_core_oe = 17'h0ff0f;
		rf_sw_level = 10'h155;
		pulse_out = 6'h01;
		coex_general_io_oe = 6'h01;
		do_reset;
		tick(3);
		por_released = 1'b1;
		// Bounded wait for the strap capture after POR release
		for (n = 0; n < D + 20 && strap_done !== 1'b1; n++)
			tick(1);
		// A capture that never came counts here and again in strap_wait; the run still ends in results
		if (n == D + 20) begin
			num_errors++;
		end
		chk("strap_wait", 1, n >= D + 3 && n <= D + 5); // Capture delayed
		chk("straps", 7'h55, straps);
		pu_gpio = '0;
		pu_rf = '0;
		tick(3);
		chk("straps_held", 7'h55, straps); // Latched once
		chk("gpio_pd_en", 0, gpio_pd_en); // Pulls off after capture
		chk("gpio_out", gpio_core_out, gpio_out); // Function one
		chk("gpio_oe", gpio_core_oe, gpio_oe); // Function one
		chk("rf_out", rf_sw_level, rf_out); // Software levels
		chk("rf_oe", 10'h3ff, rf_oe); // All lines driven
		chk("rf_pd_en", 0, rf_pd_en); // Pulls off after capture
		chk("core_in", 17'h1a5e5, gpio_core_in); // Pad levels to core
		chk("coex_in", 6'h19, coex_general_io_in); // Coex inputs
		chk("jtag_off", 4'b0100, {jtag_tck, jtag_tms, jtag_tdi, jtag_trst_n});
		wr(2, FUNC_COEX);
		chk("coex_pad", 2'b10, {gpio_oe[2], gpio_out[2]}); // Coex on pad 2
		wr(27, FUNC_ALT2);
		chk("bad_pad", 17'h1a5a1, gpio_out); // Index 27 ignored
		wr(14, FUNC_ALT2);
		chk("pwm_pad", 2'b11, {gpio_oe[14], gpio_out[14]}); // Pulse 0 on pad 14
		jtag_select = 1'b1;
		tick(3);
		chk("jtag_pads", 3'b100, {gpio_oe[5], gpio_out[5], gpio_oe[2]}); // Override
		// Released pads settle, then cross the synchroniser
		tick(3);
		chk("jtag_on", 4'b1101, {jtag_tck, jtag_tms, jtag_tdi, jtag_trst_n});
		jtag_select = 1'b0;
		tick(3);
		chk("jtag_gone", 2'b01, {gpio_oe[5], gpio_out[5]}); // Pins back
		wr(RF_BASE + RF_RX_A, FUNC_ALT2);
		tick(2);
		chk("dbg_rx", 0, debug_serial_rx); // Second UART on RF 6
		wr(RF_BASE + RF_TX_A, FUNC_ALT2);
		chk("dbg_tx", 1, rf_out[7]); // Second UART on RF 7
		wr(RF_BASE + RF_RX_A, FUNC_ALT3);
		chk("coex_rx", 0, coex_serial_in); // Third UART on RF 6
		chk("audio", 2'b10, {audio_data_out_1, audio_data_out_0}); // Plain stream
		spdif_enable = 2'b01;
		tick(2);
		chk("spdif0", 2'b11, {audio_data_out_1, audio_data_out_0});
		spdif_enable = 2'b10;
		spdif_data = 1'b0;
		tick(2);
		chk("spdif1", 2'b00, {audio_data_out_1, audio_data_out_0});
		usb_role_select = 1'b1;
		tick(3);
		chk("usb_role", 1, usb_host_mode); // Role pin followed
		// Two-wire tried on port 0 only; boards should avoid it
		two_wire_mode = 2'b01;
		scl_drive_low = 2'b01;
		spi_mosi = 2'b11;
		spi_miso_pad = 2'b01;
		tick(3);
		chk("spi_clk_pad", 4'b1110, {spi_clk_pad_oe, spi_clk_pad});
		chk("spi_mosi_pad", 4'b1010, {spi_mosi_pad_oe, spi_mosi_pad});
		chk("spi_miso", 2'b01, spi_miso);
		chk("sda_in", 2'b10, two_wire_sda_in); // Data read back
		do_reset;
		results;
	end
endmodule
